/* hw/eik_pkg.sv */
/*
 Package for the external interrupt and keyboard interrupt block: register address,
 bit positions, reset values and the sensitivity option encoding.
 Assumes an 8-bit I/O register space of 32 bytes starting at address zero.
*/
// Function
// - Active-low interrupt pin is asynchronous; synchronise it before clocked use.
// - Build option picks falling-edge only or falling-edge plus low-level sensitivity.
// - Build option ORs port A bits 0 to 3 into the interrupt request.
// - Keyboard pins use inverted polarity: rising edge or high level is active.
// - The chosen edge or edge-plus-level sensitivity applies to keyboard pins too.
// - Status and control register answers at address 0x0d in I/O space.
// - Bit 7 enable read/write, bit 3 pending read-only, bit 1 clear write-only.
// - Software mask bit, request bit and clear bit block, observe and acknowledge the request.
package eik_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] EIK_ADDR_STATUS_CONTROL = 5'h0d;
    localparam int EIK_BIT_ENABLE = 7;
    localparam int EIK_BIT_PENDING = 3;
    localparam int EIK_BIT_CLEAR = 1;
    localparam logic EIK_RST_ENABLE = 1'h0;
    localparam logic EIK_RST_PENDING = 1'h0;
    localparam int EIK_KBD_WIDTH = 4;
    localparam int EIK_SYNC_STAGES = 2;
    // Idle pin levels: interrupt pin high, keyboard pins low.
    localparam logic [EIK_KBD_WIDTH:0] EIK_RST_PINS = 5'h10;
    localparam logic [7:0] EIK_RST_RDATA = 8'h00;
    localparam logic EIK_RST_IRQ = 1'h0;

    // ------------------------------------------------------------
    // Sensitivity option
    // ------------------------------------------------------------
    typedef enum logic {EIK_EDGE_ONLY, EIK_EDGE_LEVEL} eik_sense_t;
endpackage

/* hw/eik_sync.sv */
/*
 Two-flop synchroniser for a vector of asynchronous pin levels.
 Assumes a free-running clock and a reset value supplied as a constant.
*/
`timescale 1ns/1ps
module eik_sync
    import eik_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second; nothing else may look at it.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end
        else
        begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

/* hw/eik_ext_irq.sv */
/*
 External interrupt input logic with optional keyboard pins ORed in.
 Holds the status/control register and drives one interrupt request to the CPU.
 Assumes a simple synchronous 8-bit register port: address, write strobe, read strobe.
*/
`timescale 1ns/1ps
module eik_ext_irq
    import eik_pkg::*;
#(
    parameter eik_sense_t SENSE = EIK_EDGE_LEVEL,
    parameter bit KBD_ENABLE = 1'b1
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic extIntPin_n,
    input wire logic [EIK_KBD_WIDTH-1:0] keyboardPortPins,
    input wire logic [4:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata_q,
    output logic cpuIrq_q
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [EIK_KBD_WIDTH:0] pinsSync;
    logic [EIK_KBD_WIDTH:0] pinsPrev_q;

    // Pins reset to their idle levels so that reset release is not seen as an edge.
    eik_sync #(
        .WIDTH(EIK_KBD_WIDTH + 1),
        .RESET_VALUE(EIK_RST_PINS)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn({extIntPin_n, keyboardPortPins}),
        .syncOut(pinsSync)
    );

    // ------------------------------------------------------------
    // Source combining
    // ------------------------------------------------------------
    // One decode serves the current and the previous sample, so the two cannot drift apart.
    function automatic logic srcLevel(input logic [EIK_KBD_WIDTH:0] pins);
        logic pinLow;
        logic kbdHigh;
        pinLow = ~pins[EIK_KBD_WIDTH];
        kbdHigh = KBD_ENABLE ? (|pins[EIK_KBD_WIDTH-1:0]) : 1'h0;
        return pinLow | kbdHigh;
    endfunction

    wire logic srcActive = srcLevel(pinsSync);
    wire logic srcPrevActive = srcLevel(pinsPrev_q);
    // Edges are taken on the ORed level, as a wired-OR line would show them.
    wire logic edgeSeen = srcActive & ~srcPrevActive;
    wire logic levelSeen = (SENSE == EIK_EDGE_LEVEL) & srcActive;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire logic selStatus = (regAddr == EIK_ADDR_STATUS_CONTROL);
    wire logic wrStatus = regWrite & selStatus;
    wire logic clearReq = wrStatus & regWdata[EIK_BIT_CLEAR];

    logic enable_q;
    logic enable_d;
    logic edgeLatch_q;
    logic edgeLatch_d;
    logic [7:0] regRdata_d;

    assign enable_d = wrStatus ? regWdata[EIK_BIT_ENABLE] : enable_q;
    // A new edge in the clearing cycle wins, so no event is lost.
    assign edgeLatch_d = edgeSeen | (edgeLatch_q & ~clearReq);
    wire logic pendingFlag = edgeLatch_q | levelSeen;

    always_comb
    begin
        regRdata_d = 8'h00;
        if (regRead && selStatus)
        begin
            regRdata_d[EIK_BIT_ENABLE] = enable_q;
            regRdata_d[EIK_BIT_PENDING] = pendingFlag;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // The previous sample only ever sees the second synchroniser stage.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinsPrev_q <= EIK_RST_PINS;
        end
        else
        begin
            pinsPrev_q <= pinsSync;
        end
    end

    a_sync_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n, 2) |-> (pinsSync[EIK_KBD_WIDTH] == $past(extIntPin_n, 2))
            && (pinsSync[EIK_KBD_WIDTH-1:0] == $past(keyboardPortPins, 2)))
        else $error("Pins not delayed by exactly two synchroniser stages.");

    a_pin_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(extIntPin_n) |-> ##2 !pinsSync[EIK_KBD_WIDTH])
        else $error("Pin not synchronised within two cycles.");

    a_kbd_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!KBD_ENABLE && pinsSync[EIK_KBD_WIDTH]) |-> !srcActive)
        else $error("Keyboard pin reached the request while disabled.");

    a_kbd_rise_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (KBD_ENABLE && !srcPrevActive && (|pinsSync[EIK_KBD_WIDTH-1:0])) |-> edgeSeen)
        else $error("Rising keyboard pin not seen as an edge.");

    a_pin_fall_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!srcPrevActive && !pinsSync[EIK_KBD_WIDTH]) |-> edgeSeen)
        else $error("Falling interrupt pin not seen as an edge.");

    a_level_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (SENSE == EIK_EDGE_LEVEL && srcActive) |-> pendingFlag)
        else $error("Active level not reported in level mode.");

    a_edge_only_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (SENSE == EIK_EDGE_ONLY && !edgeLatch_q) |-> !pendingFlag)
        else $error("Level reported as pending in edge-only mode.");

    a_level_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!srcActive && !edgeLatch_q) |-> !pendingFlag)
        else $error("Pending reported with no level and no latched edge.");

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_q <= EIK_RST_ENABLE;
            edgeLatch_q <= EIK_RST_PENDING;
        end
        else
        begin
            enable_q <= enable_d;
            edgeLatch_q <= edgeLatch_d;
        end
    end

    a_edge_sets_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        edgeSeen |=> edgeLatch_q)
        else $error("Detected edge did not set the pending latch.");

    a_clear_drops_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clearReq && !edgeSeen) |=> !edgeLatch_q)
        else $error("Clear request did not drop the pending latch.");

    a_latch_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (edgeLatch_q && !clearReq) |=> edgeLatch_q)
        else $error("Pending latch dropped without a clear.");

    a_no_spurious_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!edgeSeen && !edgeLatch_q) |=> !edgeLatch_q)
        else $error("Pending latch set without an edge.");

    a_latch_needs_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(edgeLatch_q) |-> $past(edgeSeen))
        else $error("Pending latch rose without a detected edge.");

    a_write_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrStatus |=> (enable_q == $past(regWdata[EIK_BIT_ENABLE])))
        else $error("Enable bit did not take the written value.");

    a_enable_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wrStatus |=> $stable(enable_q))
        else $error("Enable bit changed without a status write.");

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Both outputs leave through flip-flops, so decode glitches never reach the CPU.
    wire logic irqNext = enable_q & pendingFlag;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regRdata_q <= EIK_RST_RDATA;
            cpuIrq_q <= EIK_RST_IRQ;
        end
        else
        begin
            regRdata_q <= regRdata_d;
            cpuIrq_q <= irqNext;
        end
    end

    a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !enable_q |=> !cpuIrq_q)
        else $error("Interrupt reached the CPU while disabled.");

    a_irq_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enable_q && pendingFlag) |=> cpuIrq_q)
        else $error("Enabled pending interrupt not raised.");

    a_irq_drops: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !pendingFlag |=> !cpuIrq_q)
        else $error("Interrupt stayed up with nothing pending.");

    a_irq_needs_source: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpuIrq_q |-> ($past(enable_q) && $past(pendingFlag)))
        else $error("Interrupt raised without an enabled pending source.");

    a_read_layout: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (regRead && selStatus) |=> (regRdata_q[EIK_BIT_CLEAR] == 1'h0)
            && (regRdata_q[EIK_BIT_ENABLE] == $past(enable_q)))
        else $error("Status register read layout wrong.");

    a_read_pending: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (regRead && selStatus) |=> (regRdata_q[EIK_BIT_PENDING] == $past(pendingFlag)))
        else $error("Pending bit read back wrong.");

    a_read_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (regRead && selStatus) |=> ((regRdata_q & 8'h77) == 8'h00))
        else $error("Unused status bits did not read as zero.");

    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(regRead && selStatus) |=> (regRdata_q == 8'h00))
        else $error("Read data not zero outside a status read.");
endmodule

/* dv/eik_pin_model.sv */
/*
 Sources on the far side of the pins: a wired-OR interrupt line and four keyboard switches.
 Assumes the bench commands each source level off the sampling edge.
*/
`timescale 1ns/1ps
module eik_pin_model(
    input wire logic irqAct,
    input wire logic [3:0] keyAct,
    output logic extIntPin_n,
    output logic [3:0] keyboardPortPins
);
    // The line has a pull-up, so a released source leaves it high, never stale.
    assign extIntPin_n = ~irqAct;
    // Switches close to the high level; the pulldowns return them low when open.
    assign keyboardPortPins = keyAct;
endmodule

/* dv/eik_ext_irq_bench.sv */
/*
 Bench for the external interrupt block: an edge+level build (dut), an edge-only build
 (dutE) and an edge-only build without keyboard pins (dutN) share every input.
 Assumes the package, design and pin model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin badCount++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module eik_ext_irq_bench;
    import eik_pkg::*;
    logic ref_clk, rst_n, irqAct, extIntPin_n, regWrite, regRead, irqL, ext_int_enable, irqN;
    logic [3:0] keyAct, keyboardPortPins;
    logic [4:0] regAddr;
    logic [7:0] regWdata, rdL, rdE, rdN;
    int badCount, numChecks;
    eik_pin_model src (.irqAct, .keyAct, .extIntPin_n, .keyboardPortPins);
    eik_ext_irq #(.SENSE(EIK_EDGE_LEVEL), .KBD_ENABLE(1'b1)) dut (.ref_clk, .rst_n,
        .extIntPin_n, .keyboardPortPins, .regAddr, .regWrite, .regRead, .regWdata,
        .regRdata_q(rdL), .cpuIrq_q(irqL));
    eik_ext_irq #(.SENSE(EIK_EDGE_ONLY), .KBD_ENABLE(1'b1)) dutE (.ref_clk, .rst_n,
        .extIntPin_n, .keyboardPortPins, .regAddr, .regWrite, .regRead, .regWdata,
        .regRdata_q(rdE), .cpuIrq_q(ext_int_enable));
    // Keyboard pins left out of the request: only the interrupt pin may raise it.
    eik_ext_irq #(.SENSE(EIK_EDGE_ONLY), .KBD_ENABLE(1'h0)) dutN (.ref_clk, .rst_n,
        .extIntPin_n, .keyboardPortPins, .regAddr, .regWrite, .regRead, .regWdata,
        .regRdata_q(rdN), .cpuIrq_q(irqN));
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {regAddr, regWdata, regWrite} = {a, d, 1'b1};
        @(negedge ref_clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] eL, input logic [7:0] eE);
        @(negedge ref_clk);
        {regAddr, regRead} = {a, 1'b1};
        @(negedge ref_clk);
        regRead = 1'b0;
        `CHK("read level build", eL, rdL)
        `CHK("read edge build", eE, rdE)
    endtask
    task automatic irq(input logic eL, input logic eE);
        `CHK("request level build", eL, irqL)
        `CHK("request edge build", eE, ext_int_enable)
    endtask
    task automatic t_regs;
        wr(5'h0c, 8'hff);
        rd(5'h0d, 8'h00, 8'h00);
        rd(5'h0c, 8'h00, 8'h00);
        wr(5'h0d, 8'hff);
        rd(5'h0d, 8'h80, 8'h80);
        $display("test regs done");
    endtask
    task automatic t_keys;
        for (int k = 0; k < 5; k++)
        begin
            // Index 4 stands for the interrupt pin itself, pulsed like the keys.
            irqAct = (k == 4);
            keyAct = 4'h1 << k;
            cyc(2);
            {irqAct, keyAct} = 5'h00;
            cyc(6);
            irq(1'b1, 1'b1);
            `CHK("request no-key build", (k == 4), irqN)
            rd(5'h0d, 8'h88, 8'h88);
            `CHK("read no-key build", (k == 4) ? 8'h88 : 8'h80, rdN)
            wr(5'h0d, 8'h82);
            cyc(2);
            irq(1'b0, 1'b0);
            `CHK("request no-key build", 1'b0, irqN)
        end
        $display("test edges done");
    endtask
    task automatic t_level;
        for (int i = 0; i < 2; i++)
        begin
            irqAct = (i == 0);
            keyAct = (i == 1) ? 4'h8 : 4'h0;
            cyc(6);
            wr(5'h0d, 8'h82);
            cyc(2);
            irq(1'b1, 1'b0);
            rd(5'h0d, 8'h88, 8'h80);
            {irqAct, keyAct} = 5'h00;
            cyc(4);
            irq(1'b0, 1'b0);
        end
        $display("test level done");
    endtask
    task automatic t_mask;
        wr(5'h0d, 8'h00);
        irqAct = 1'b1;
        cyc(2);
        irqAct = 1'b0;
        cyc(6);
        irq(1'b0, 1'b0);
        rd(5'h0d, 8'h08, 8'h08);
        wr(5'h0d, 8'h80);
        cyc(2);
        irq(1'b1, 1'b1);
        $display("test mask done");
    endtask
    task automatic tallyAndFinish;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial
    begin
        {rst_n, irqAct, keyAct, regAddr, regWrite, regRead, regWdata} = '0;
        cyc(16);
        rst_n = 1'b1;
        t_regs();
        t_keys();
        t_level();
        t_mask();
        tallyAndFinish();
    end
    // The tests need well under a thousand cycles; this span leaves a wide margin.
    initial
    begin
        #20000;
        badCount++;
        tallyAndFinish();
    end
endmodule
